/* File: rstsq_pkg.sv */
// constants and types for the reset and stop-recovery sequencer
package rstsq_pkg;

    // hold lengths and reset-pin filter length, in cycles
    localparam int WDT_HOLD_CYC = 66;
    localparam int SYS_HOLD_CYC = 16;
    localparam int PIN_FILT_CYC = 4;
    localparam logic [6:0] WDT_LAST = 7'(WDT_HOLD_CYC - 1);
    localparam logic [6:0] SYS_LAST = 7'(SYS_HOLD_CYC - 1);
    localparam logic [2:0] PIN_LAST = 3'(PIN_FILT_CYC - 1);

    // port address value that opens the recovery source enable
    localparam logic [7:0] PADDR_RECOV = 8'h05;
    localparam logic [7:0] PADDR_RST = 8'h00;
    localparam logic [7:0] RECOV_EN_RST = 8'h00;
    localparam logic SM_RST = 1'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // program memory locations of the start vector
    localparam logic [15:0] VEC_ADDR_HI = 16'h0002;
    localparam logic [15:0] VEC_ADDR_LO = 16'h0003;

    // watchdog_ctrl_reg field positions
    localparam int WDC_POR = 7;
    localparam int WDC_STOP = 6;
    localparam int WDC_WDT = 5;
    localparam int WDC_EXT = 4;
    localparam int WDC_SM = 0;
    localparam logic [2:0] WDC_RSVD = 3'h0;

    // synchroniser width: por, reset pin, debug pin, osc, 8 port pins
    localparam int SYNC_W = 12;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_WCNT = 4'h2,
        ST_SCNT = 4'h4,
        ST_STOP = 4'h8
    } rstsq_state_t;

endpackage : rstsq_pkg

/* File: rstsq_sync.sv */
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module rstsq_sync
    import rstsq_pkg::*;
#(
    parameter int W = SYNC_W
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    meta_r[g] <= 1'h0;
                    sync_r[g] <= 1'h0;
                end else begin
                    meta_r[g] <= d_i[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign q_o = sync_r;
endmodule : rstsq_sync
`default_nettype wire

/* File: rstsq_ctrl.sv */
// reset and stop-mode recovery sequencer
//
// Behaviour
// - any system reset holds the core 66 watchdog-osc then 16 clock cycles
// - at start of a system reset all GPIO pins become inputs
// - core idle in reset; system clock starts after watchdog-osc count
// - system reset loads control registers with their reset values
// - after the hold, the core fetches its start vector from 0002H/0003H
// - power-on or brown-out overrides every other reset source
// - run/halt resets: power-on, watchdog, reset pin, debugger request
// - in stop: only power-on, reset pin or debug pin low give reset
// - watchdog time-out resets only while the reset option bit is 1
// - a watchdog reset sets the watchdog time-out flag
// - reset pin must stay low four clock cycles before reset starts
// - reset held while pin low; release right after pin goes high
// - a reset from the pin sets the external-reset flag
// - debugger reset resets all but the debugger block
// - debugger request bit cleared by hardware; power-on flag set after
// - stop mode entered only by the stop instruction
// - stop recovery holds core 66 watchdog-osc then 16 clock cycles
// - stop recovery changes only the watchdog control register
// - every stop recovery sets the stop-recovery flag
// - recovery enable reached via port control when address is 05H
// - enabled pin transition in stop starts recovery; bits reset to 0
// - reading watchdog_ctrl_reg clears the four status flags
// - stop_watchdog_disable set stops watchdog and its osc in stop
`timescale 1ns/10ps
`default_nettype none
module rstsq_ctrl
    import rstsq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic rst_pin_n_i,
    input wire logic debug_pin_n_i,
    input wire logic wdt_osc_i,
    input wire logic [7:0] port_pin_i,
    input wire logic wdt_timeout_i,
    input wire logic watchdog_reset_option_i,
    input wire logic dbg_rst_req_i,
    input wire logic stop_instr_i,
    input wire logic [7:0] wdata_i,
    input wire logic paddr_wr_i,
    input wire logic pctl_wr_i,
    input wire logic pctl_rd_i,
    input wire logic wdc_wr_i,
    input wire logic wdc_rd_i,
    output logic [7:0] rdata_o,
    output logic core_rst_o,
    output logic regfile_rst_o,
    output logic dbg_blk_rst_o,
    output logic gpio_in_o,
    output logic sysclk_en_o,
    output logic wdt_osc_en_o,
    output logic stop_mode_o,
    output logic vec_fetch_o,
    output logic [15:0] vec_addr_hi_o,
    output logic [15:0] vec_addr_lo_o,
    output logic dbg_rst_clr_o
);
    logic [SYNC_W-1:0] sync_q;
    logic por_s;
    logic pin_n_s;
    logic dbg_n_s;
    logic osc_s;
    logic [7:0] port_s;
    logic osc_d_r;
    logic osc_rise;
    logic [7:0] port_d_r;
    logic recov_hit;
    logic [2:0] pin_cnt_r;
    logic pin_low_r;
    rstsq_state_t state_r;
    rstsq_state_t state_nxt;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic in_rst;
    logic start_sys;
    logic start_rec;
    logic by_pin;
    logic by_wdt;
    logic by_dbg;
    logic rec_wdt;
    logic done;
    logic hold_on;
    logic kind_sys_r;
    logic kind_dbg_r;
    logic por_f_r;
    logic stop_f_r;
    logic wdt_f_r;
    logic ext_f_r;
    logic sm_r;
    logic [7:0] paddr_r;
    logic [7:0] recov_en_r;
    logic [7:0] wdc_val;

    // all pin-side inputs cross into the clock domain here
    rstsq_sync #(
        .W(SYNC_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({port_pin_i, wdt_osc_i, debug_pin_n_i, rst_pin_n_i, por_i}),
        .q_o(sync_q)
    );

    assign por_s = sync_q[0];
    assign pin_n_s = sync_q[1];
    assign dbg_n_s = sync_q[2];
    assign osc_s = sync_q[3];
    assign port_s = sync_q[11:4];

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            osc_d_r <= 1'h0;
            port_d_r <= 8'h00;
        end else begin
            osc_d_r <= osc_s;
            port_d_r <= port_s;
        end
    end

    assign osc_rise = osc_s & ~osc_d_r;
    assign recov_hit = |((port_s ^ port_d_r) & recov_en_r);

    // low-level filter on the synchronised reset pin
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_cnt_r <= 3'h0;
            pin_low_r <= 1'h0;
        end else if (pin_n_s) begin
            pin_cnt_r <= 3'h0;
            pin_low_r <= 1'h0;
        end else if (pin_cnt_r == PIN_LAST) begin
            pin_low_r <= 1'h1;
        end else begin
            pin_cnt_r <= pin_cnt_r + 3'h1;
        end
    end

    assign in_rst = (state_r == ST_WCNT) || (state_r == ST_SCNT);

    // reset and recovery source selection per operating mode
    always_comb begin
        by_pin = 1'h0;
        by_wdt = 1'h0;
        by_dbg = 1'h0;
        rec_wdt = 1'h0;
        start_rec = 1'h0;
        case (state_r)
            ST_RUN: begin
                by_pin = pin_low_r;
                by_wdt = wdt_timeout_i & watchdog_reset_option_i;
                by_dbg = dbg_rst_req_i;
            end
            ST_STOP: begin
                by_pin = pin_low_r | ~dbg_n_s;
                rec_wdt = wdt_timeout_i & ~sm_r;
                start_rec = ~by_pin & (recov_hit | rec_wdt);
            end
            default: begin
                by_pin = 1'h0;
            end
        endcase
        if (por_s) begin
            by_pin = 1'h0;
            by_wdt = 1'h0;
            by_dbg = 1'h0;
            rec_wdt = 1'h0;
            start_rec = 1'h0;
        end
        start_sys = by_pin | by_wdt | by_dbg;
    end

    // a pin still held low keeps the core in reset past the count
    assign done = (state_r == ST_SCNT) && (cnt_r == SYS_LAST) && !pin_low_r;
    // core leaves reset on the same edge as the vector fetch pulse
    assign hold_on = in_rst && !done;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_RUN: begin
                if (start_sys) begin
                    state_nxt = ST_WCNT;
                    cnt_nxt = 7'h00;
                end else if (stop_instr_i) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (start_sys || start_rec) begin
                    state_nxt = ST_WCNT;
                    cnt_nxt = 7'h00;
                end
            end
            ST_WCNT: begin
                if (osc_rise && cnt_r == WDT_LAST) begin
                    state_nxt = ST_SCNT;
                    cnt_nxt = 7'h00;
                end else if (osc_rise) begin
                    cnt_nxt = cnt_r + 7'h01;
                end
            end
            ST_SCNT: begin
                if (done) begin
                    state_nxt = ST_RUN;
                end else if (cnt_r != SYS_LAST) begin
                    cnt_nxt = cnt_r + 7'h01;
                end
            end
            default: begin
                state_nxt = ST_WCNT;
                cnt_nxt = 7'h00;
            end
        endcase
        if (por_s) begin
            state_nxt = ST_WCNT;
            cnt_nxt = 7'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_WCNT;
            cnt_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // kind of the reset in progress
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || por_s) begin
            kind_sys_r <= 1'h1;
            kind_dbg_r <= 1'h0;
        end else if (start_sys) begin
            kind_sys_r <= 1'h1;
            kind_dbg_r <= by_dbg;
        end else if (start_rec) begin
            kind_sys_r <= 1'h0;
            kind_dbg_r <= 1'h0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            core_rst_o <= 1'h1;
            regfile_rst_o <= 1'h1;
            dbg_blk_rst_o <= 1'h1;
            gpio_in_o <= 1'h1;
            sysclk_en_o <= 1'h0;
            wdt_osc_en_o <= 1'h1;
            stop_mode_o <= 1'h0;
            vec_fetch_o <= 1'h0;
            dbg_rst_clr_o <= 1'h0;
        end else begin
            core_rst_o <= hold_on;
            regfile_rst_o <= hold_on & kind_sys_r;
            dbg_blk_rst_o <= hold_on & kind_sys_r & ~kind_dbg_r;
            gpio_in_o <= hold_on & kind_sys_r;
            sysclk_en_o <= state_nxt != ST_WCNT;
            wdt_osc_en_o <= !(state_r == ST_STOP && sm_r);
            stop_mode_o <= state_r == ST_STOP;
            vec_fetch_o <= done;
            dbg_rst_clr_o <= by_dbg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            vec_addr_hi_o <= VEC_ADDR_HI;
            vec_addr_lo_o <= VEC_ADDR_LO;
        end
    end

    // status flags: a read clears, a same-cycle event wins
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || por_s) begin
            por_f_r <= 1'h1;
            stop_f_r <= 1'h0;
            wdt_f_r <= 1'h0;
            ext_f_r <= 1'h0;
        end else begin
            if (done && kind_dbg_r) begin
                por_f_r <= 1'h1;
            end else if (rec_wdt && start_rec) begin
                por_f_r <= 1'h0;
            end else if (wdc_rd_i) begin
                por_f_r <= 1'h0;
            end
            if (start_rec) begin
                stop_f_r <= 1'h1;
            end else if (by_wdt || wdc_rd_i) begin
                stop_f_r <= 1'h0;
            end
            if (by_wdt || (start_rec && rec_wdt)) begin
                wdt_f_r <= 1'h1;
            end else if (start_rec || wdc_rd_i) begin
                wdt_f_r <= 1'h0;
            end
            if (by_pin && pin_low_r) begin
                ext_f_r <= 1'h1;
            end else if (start_rec || wdc_rd_i) begin
                ext_f_r <= 1'h0;
            end
        end
    end

    // control registers; stop recovery leaves them alone
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || por_s || start_sys) begin
            sm_r <= SM_RST;
            paddr_r <= PADDR_RST;
            recov_en_r <= RECOV_EN_RST;
        end else begin
            if (wdc_wr_i) begin
                sm_r <= wdata_i[WDC_SM];
            end
            if (paddr_wr_i) begin
                paddr_r <= wdata_i;
            end
            if (pctl_wr_i && paddr_r == PADDR_RECOV) begin
                recov_en_r <= wdata_i;
            end
        end
    end

    assign wdc_val = {por_f_r, stop_f_r, wdt_f_r, ext_f_r, WDC_RSVD, sm_r};

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= RDATA_RST;
        end else if (wdc_rd_i) begin
            rdata_o <= wdc_val;
        end else if (pctl_rd_i) begin
            rdata_o <= (paddr_r == PADDR_RECOV) ? recov_en_r : 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_wdt_count_end: assert property (
        state_r == ST_WCNT && osc_rise && cnt_r == WDT_LAST && !por_s
        |=> state_r == ST_SCNT && cnt_r == 7'h00)
        else $error("watchdog count did not hand over to clock count");

    chk_sys_count_hold: assert property (
        state_r == ST_SCNT && cnt_r != SYS_LAST && !por_s
        |=> state_r == ST_SCNT && cnt_r == $past(cnt_r) + 7'h01)
        else $error("clock hold left early");

    chk_gpio_input: assert property (
        core_rst_o && regfile_rst_o |-> gpio_in_o)
        else $error("gpio not forced to input during system reset");

    chk_clk_gate: assert property (
        state_r == ST_WCNT && state_nxt == ST_WCNT |=> !sysclk_en_o && core_rst_o)
        else $error("system clock enabled during watchdog count");

    chk_vec_fetch: assert property (
        vec_fetch_o |-> $past(state_r) == ST_SCNT && !core_rst_o
        && vec_addr_hi_o == VEC_ADDR_HI)
        else $error("vector fetch not at end of hold");

    chk_por_prio: assert property (
        por_s |=> state_r == ST_WCNT && cnt_r == 7'h00 && por_f_r)
        else $error("power-on did not restart the sequence");

    chk_wdt_option: assert property (
        state_r == ST_RUN && wdt_timeout_i && !watchdog_reset_option_i
        && !por_s && !pin_low_r && !dbg_rst_req_i |=> !in_rst)
        else $error("watchdog reset without option bit");

    chk_pin_filter: assert property (
        $rose(pin_low_r) |-> $past(!pin_n_s, 1) && $past(!pin_n_s, 2)
        && $past(!pin_n_s, 3) && $past(!pin_n_s, 4))
        else $error("reset pin accepted under four cycles");

    chk_pin_hold: assert property (
        in_rst && pin_low_r && !por_s |=> in_rst)
        else $error("reset released while pin still low");

    chk_stop_entry: assert property (
        $rose(state_r == ST_STOP) |-> $past(stop_instr_i))
        else $error("stop mode without stop instruction");

    chk_read_clear: assert property (
        wdc_rd_i && !por_s && !start_sys && !start_rec
        |=> !stop_f_r && !ext_f_r)
        else $error("status read did not clear flags");

    chk_dbg_clear: assert property (
        by_dbg |=> dbg_rst_clr_o && state_r == ST_WCNT)
        else $error("debugger request not cleared");

endmodule : rstsq_ctrl
`default_nettype wire

/* File: rstsq_far_model.sv */
// far-side model: reset pin, debug pin, port pins, debugger request, watchdog oscillator
`timescale 1ns/10ps
`default_nettype none
module rstsq_far_model (
    input wire logic sys_clk_i,
    input wire logic pin_lo_i,
    input wire logic dbg_lo_i,
    input wire logic [7:0] port_i,
    input wire logic dbg_set_i,
    input wire logic dbg_rst_clr_i,
    input wire logic osc_en_i,
    output logic rst_pin_n_o,
    output logic debug_pin_n_o,
    output logic [7:0] port_pin_o,
    output logic dbg_rst_req_o,
    output logic wdt_osc_o
);
    // released pins go to their pull-up level
    assign rst_pin_n_o = !pin_lo_i;
    assign debug_pin_n_o = !dbg_lo_i;
    assign port_pin_o = port_i;
    initial wdt_osc_o = 1'b0;
    // rc oscillator, unrelated to the system clock, halts when disabled
    always begin
        #11.5;
        wdt_osc_o = osc_en_i ? !wdt_osc_o : 1'b0;
    end
    // request bit stays set until the device clears it
    initial dbg_rst_req_o = 1'b0;
    always @(posedge sys_clk_i) begin
        if (dbg_set_i) begin
            dbg_rst_req_o <= 1'b1;
        end else if (dbg_rst_clr_i) begin
            dbg_rst_req_o <= 1'b0;
        end
    end
endmodule : rstsq_far_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the reset and stop-recovery sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, por_i = 1'b0, wdt_to = 1'b0, wopt = 1'b1;
    logic stop_i = 1'b0, paddr_wr = 1'b0, pctl_wr = 1'b0, pctl_rd = 1'b0;
    logic wdc_wr = 1'b0, wdc_rd = 1'b0, pin_lo = 1'b0, dbg_lo = 1'b0, dbg_set = 1'b0;
    logic [7:0] wdata = 8'h00, port_v = 8'h00, rdata, pins, en;
    logic rst_n, dbg_n, osc, req, core_rst, rf_rst, dbg_rst, gpio_in, sck_en, osc_en;
    logic stop_m, vec_f, clr;
    logic [15:0] va_hi, va_lo;
    logic [31:0] seed = 32'h4E7E3C8D;
    int err_count = 0, checks = 0, cycle = 0, n;

    always #4 sys_clk_i = !sys_clk_i;

    rstsq_far_model rstsq_far_model_inst (.sys_clk_i(sys_clk_i), .pin_lo_i(pin_lo),
        .dbg_lo_i(dbg_lo), .port_i(port_v), .dbg_set_i(dbg_set), .dbg_rst_clr_i(clr),
        .osc_en_i(osc_en), .rst_pin_n_o(rst_n), .debug_pin_n_o(dbg_n), .port_pin_o(pins),
        .dbg_rst_req_o(req), .wdt_osc_o(osc));

    rstsq_ctrl rstsq_ctrl_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
        .rst_pin_n_i(rst_n), .debug_pin_n_i(dbg_n), .wdt_osc_i(osc), .port_pin_i(pins),
        .wdt_timeout_i(wdt_to), .watchdog_reset_option_i(wopt), .dbg_rst_req_i(req),
        .stop_instr_i(stop_i), .wdata_i(wdata), .paddr_wr_i(paddr_wr), .pctl_wr_i(pctl_wr),
        .pctl_rd_i(pctl_rd), .wdc_wr_i(wdc_wr), .wdc_rd_i(wdc_rd), .rdata_o(rdata),
        .core_rst_o(core_rst), .regfile_rst_o(rf_rst), .dbg_blk_rst_o(dbg_rst),
        .gpio_in_o(gpio_in), .sysclk_en_o(sck_en), .wdt_osc_en_o(osc_en),
        .stop_mode_o(stop_m), .vec_fetch_o(vec_f), .vec_addr_hi_o(va_hi),
        .vec_addr_lo_o(va_lo), .dbg_rst_clr_o(clr));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic final_report;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_v

    task automatic chk_c(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("BAD t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_c

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : cyc

    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge sys_clk_i);
        wdata <= d;
        paddr_wr <= (sel == 0);
        pctl_wr <= (sel == 1);
        wdc_wr <= (sel == 2);
        @(posedge sys_clk_i);
        {paddr_wr, pctl_wr, wdc_wr} <= 3'h0;
    endtask : wr

    task automatic rd(input logic wdc, input logic [7:0] exp);
        @(posedge sys_clk_i);
        pctl_rd <= !wdc;
        wdc_rd <= wdc;
        @(posedge sys_clk_i);
        {pctl_rd, wdc_rd} <= 2'h0;
        cyc(1);
        chk_v(rdata, exp);
    endtask : rd

    // waits for the hold to start, then measures both phases of it
    task automatic hold_check(input logic full, input logic dbg_exp);
        int k, slow, fast;
        k = 0;
        slow = 0;
        fast = 0;
        cyc(0);
        while (core_rst !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        chk_v(core_rst, 1'b1);
        chk_v(gpio_in, full);
        chk_v(rf_rst, full);
        chk_v(dbg_rst, dbg_exp);
        chk_v(sck_en, 1'b0);
        while (core_rst === 1'b1 && k < 600) begin
            if (sck_en === 1'b1) fast++;
            else slow++;
            cyc(1);
            k++;
        end
        chk_v(vec_f, 1'b1);
        chk_v(va_hi, 16'h0002);
        chk_v(va_lo, 16'h0003);
        chk_c(fast, 16, 16);
        chk_c(slow, 185, 200);
    endtask : hold_check

    always @(posedge sys_clk_i) begin
        cycle++;
        if (cycle == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        cyc(12);
        sys_rst_i <= 1'b0;
        hold_check(1'b1, 1'b1);
        rd(1'b1, 8'h80);
        rd(1'b1, 8'h00);
        seed = xs(seed);
        wr(0, seed[7:0] | 8'h80);
        wr(1, seed[15:8]);
        rd(1'b0, 8'h00);
        wr(0, 8'h05);
        rd(1'b0, 8'h00);
        en = (seed[23:16] & 8'h7E) | 8'h01;
        wr(1, en);
        rd(1'b0, en);
        wopt <= 1'b0;
        @(posedge sys_clk_i) wdt_to <= 1'b1;
        @(posedge sys_clk_i) wdt_to <= 1'b0;
        cyc(20);
        chk_v(core_rst, 1'b0);
        wopt <= 1'b1;
        @(posedge sys_clk_i) wdt_to <= 1'b1;
        @(posedge sys_clk_i) wdt_to <= 1'b0;
        hold_check(1'b1, 1'b1);
        rd(1'b1, 8'h20);
        for (int i = 1; i < 4; i++) begin
            @(posedge sys_clk_i) pin_lo <= 1'b1;
            cyc(i - 1);
            @(posedge sys_clk_i) pin_lo <= 1'b0;
            cyc(12);
            chk_v(core_rst, 1'b0);
        end
        seed = xs(seed);
        @(posedge sys_clk_i) pin_lo <= 1'b1;
        fork
            begin
                cyc(6 + seed[2:0]);
                @(posedge sys_clk_i) pin_lo <= 1'b0;
            end
        join_none
        hold_check(1'b1, 1'b1);
        rd(1'b1, 8'h10);
        @(posedge sys_clk_i) pin_lo <= 1'b1;
        cyc(320);
        chk_v(core_rst, 1'b1);
        @(posedge sys_clk_i) pin_lo <= 1'b0;
        n = 0;
        while (core_rst === 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk_c(n, 1, 8);
        rd(1'b1, 8'h10);
        @(posedge sys_clk_i) dbg_set <= 1'b1;
        @(posedge sys_clk_i) dbg_set <= 1'b0;
        hold_check(1'b1, 1'b0);
        chk_v(req, 1'b0);
        rd(1'b1, 8'h80);
        wr(0, 8'h05);
        wr(1, en);
        wr(2, 8'h01);
        @(posedge sys_clk_i) stop_i <= 1'b1;
        @(posedge sys_clk_i) stop_i <= 1'b0;
        cyc(4);
        chk_v(stop_m, 1'b1);
        chk_v(osc_en, 1'b0);
        @(posedge sys_clk_i) port_v <= port_v ^ 8'h80;
        @(posedge sys_clk_i) wdt_to <= 1'b1;
        @(posedge sys_clk_i) wdt_to <= 1'b0;
        cyc(12);
        chk_v(stop_m, 1'b1);
        chk_v(core_rst, 1'b0);
        @(posedge sys_clk_i) port_v <= port_v ^ 8'h01;
        hold_check(1'b0, 1'b0);
        rd(1'b0, en);
        rd(1'b1, 8'h41);
        wr(2, 8'h00);
        @(posedge sys_clk_i) stop_i <= 1'b1;
        @(posedge sys_clk_i) stop_i <= 1'b0;
        cyc(4);
        chk_v(osc_en, 1'b1);
        @(posedge sys_clk_i) wdt_to <= 1'b1;
        @(posedge sys_clk_i) wdt_to <= 1'b0;
        hold_check(1'b0, 1'b0);
        rd(1'b1, 8'h60);
        wr(2, 8'h01);
        @(posedge sys_clk_i) stop_i <= 1'b1;
        @(posedge sys_clk_i) stop_i <= 1'b0;
        cyc(6);
        chk_v(osc_en, 1'b0);
        @(posedge sys_clk_i) dbg_lo <= 1'b1;
        fork
            begin
                cyc(6);
                @(posedge sys_clk_i) dbg_lo <= 1'b0;
            end
        join_none
        hold_check(1'b1, 1'b1);
        rd(1'b1, 8'h00);
        rd(1'b0, 8'h00);
        @(posedge sys_clk_i) por_i <= 1'b1;
        cyc(5);
        @(posedge sys_clk_i) por_i <= 1'b0;
        hold_check(1'b1, 1'b1);
        rd(1'b1, 8'h80);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
